// file: rpc_consts.vh
`ifndef RPC_CONSTS_VH
`define RPC_CONSTS_VH
// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define RPC_CLK_HZ 50000000
`define RPC_DEB_MS 5
`define RPC_DEB_CYC ((`RPC_DEB_MS * `RPC_CLK_HZ) / 1000)
`define RPC_REC_DLY_S 3
`define RPC_REC_DLY_CYC (`RPC_REC_DLY_S * `RPC_CLK_HZ)
`define RPC_SEC_CYC (`RPC_CLK_HZ)
`define RPC_FLASH_MS 500
`define RPC_FLASH_CYC (`RPC_FLASH_MS * (`RPC_CLK_HZ / 1000))
`define RPC_DTAP_MS 300
`define RPC_DTAP_RST (`RPC_DTAP_MS * (`RPC_CLK_HZ / 1000))
`define RPC_DAY_S 17'h1517F
// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define RPC_A_CTRL 8'h00
`define RPC_A_STAT 8'h04
`define RPC_A_DTAP 8'h08
`define RPC_A_RDUR 8'h0C
`define RPC_A_TOD 8'h10
`define RPC_A_STC 8'h14
`define RPC_A_NAME 8'h18
`define RPC_A_NAME2 8'h1C
`define RPC_A_CIDX 8'h20
`define RPC_A_CDAT 8'h24
`define RPC_A_CDEL 8'h28
`define RPC_A_CCNT 8'h2C
`define RPC_A_SFX0 8'h30
`define RPC_A_SFX1 8'h34
`define RPC_A_SFX2 8'h38
// ----------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------
`define RPC_B_AUTO 0
`define RPC_B_WCLK 1
`define RPC_B_RELOAD 2
`define RPC_RST_RDUR 16'h0708
`define RPC_RST_NAME 32'h52454330
`define RPC_RST_NAME2 24'h303030
`define RPC_RST_SFX 80'h45444342414A49484746
`define RPC_CLIP_MAX 10'h1F4
// ----------------------------------------------------------------
// Channel commands
// ----------------------------------------------------------------
`define RPC_CMD_LOAD 3'h1
`define RPC_CMD_PLAY 3'h2
`define RPC_CMD_CUE 3'h3
`define RPC_CMD_RSTART 3'h4
`define RPC_CMD_RSTOP 3'h5
`define RPC_CMD_CHILD 3'h6
`endif

// file: rpc_panel.v
`timescale 1ns/1ps
`include "rpc_consts.vh"
`default_nettype none
module rpc_panel #(
   parameter [31:0] DEB_CYC = `RPC_DEB_CYC,
   parameter [31:0] REC_DLY_CYC = `RPC_REC_DLY_CYC,
   parameter [31:0] SEC_CYC = `RPC_SEC_CYC,
   parameter [31:0] FLASH_CYC = `RPC_FLASH_CYC
) (
   input wire clk,
   input wire sys_rst,
   input wire [9:0] channel_function_keys,
   input wire [9:0] digit_keys,
   input wire home_key,
   input wire enter_key,
   input wire capture_key,
   input wire play_key,
   input wire stop_key,
   input wire load_key,
   input wire child_key,
   input wire [9:0] tally_input_n,
   input wire [9:0] chan_resp,
   input wire clip_in_valid,
   input wire [15:0] clip_in_desc,
   input wire [7:0] reg_addr,
   input wire [31:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   output reg [31:0] reg_rdata_q,
   output reg [9:0] green_led_q,
   output reg [9:0] red_led_q,
   output reg [3:0] disp_chan_q,
   output reg [8:0] disp_clip_q,
   output reg confirm_prompt_q,
   output reg cmd_valid_q,
   output reg [2:0] cmd_code_q,
   output reg [9:0] cmd_mask_q,
   output reg [8:0] cmd_clip_q,
   output reg [16:0] cmd_tc_q,
   output reg [55:0] cmd_name_q,
   output reg [15:0] cmd_dur_q
);
   // ----------------------------------------------------------------
   // Key debounce and press detection
   // ----------------------------------------------------------------
   localparam NK = 27;
   localparam [2:0] E_IDLE = 3'b001;
   localparam [2:0] E_HOME = 3'b010;
   localparam [2:0] E_NUM = 3'b100;
   localparam [31:0] M_ON = (FLASH_CYC / 4) * 3;
   localparam [31:0] S_ON = FLASH_CYC / 4;
   wire [NK-1:0] key_raw;
   wire [NK-1:0] deb;
   reg [NK-1:0] deb_prev_q;
   wire [NK-1:0] pr;
   assign key_raw = {child_key, load_key, stop_key, play_key, capture_key, enter_key,
                     home_key, digit_keys, channel_function_keys};
   assign pr = deb & ~deb_prev_q;
   genvar gi;
   generate
      for (gi = 0; gi < NK; gi = gi + 1) begin : g_deb
         reg s1_q;
         reg s2_q;
         reg db_q;
         reg [31:0] cnt_q;
         always @(posedge clk or posedge sys_rst) begin
            if (sys_rst) begin
               s1_q <= 1'b0;
               s2_q <= 1'b0;
               db_q <= 1'b0;
               cnt_q <= 32'h0;
            end else begin
               s1_q <= key_raw[gi];
               s2_q <= s1_q;
               if (s2_q == db_q) begin
                  cnt_q <= 32'h0;
               end else if (cnt_q >= DEB_CYC - 32'h1) begin
                  db_q <= s2_q;
                  cnt_q <= 32'h0;
               end else begin
                  cnt_q <= cnt_q + 32'h1;
               end
            end
         end
         assign deb[gi] = db_q;
      end
   endgenerate
   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   reg [9:0] t1_q, t2_q, r1_q, r2_q, air_prev_q, pend_q, gmbr_q, rec_q, rec_en_q;
   reg [3:0] sel_q, gkey_q;
   reg gang_q, conf_q, auto_q, wclk_q, rec_arm_q;
   reg [4:0] last_q;
   reg [31:0] gap_q, dtap_q, rec_cnt_q, sec_cnt_q, fl_cnt_q;
   reg [16:0] tod_q, stc_q;
   reg [15:0] rdur_q;
   reg [31:0] name_q;
   reg [23:0] name2_q;
   reg [79:0] sfx_q;
   reg [11:0] child_q;
   reg [2:0] ent_q;
   reg [9:0] num_q, ccnt_q, cidx_q;
   reg [8:0] csel_q;
   reg [8:0] loaded_q [0:9];
   reg [15:0] clip_mem [0:499];
   reg [499:0] cvld_q;
   integer i;
   // ----------------------------------------------------------------
   // Combinational decode
   // ----------------------------------------------------------------
   reg [4:0] kidx;
   reg [3:0] fidx, dig;
   reg [9:0] fbit, ctl_mask, air, chg, aplay, acue;
   reg [11:0] child_d;
   reg any_pr, dtap, m_on, s_on, rec_fire, auto_go;
   always @* begin
      kidx = 5'h0;
      fidx = 4'h0;
      dig = 4'h0;
      for (i = NK - 1; i >= 0; i = i - 1) begin
         if (pr[i]) kidx = i[4:0];
      end
      for (i = 9; i >= 0; i = i - 1) begin
         if (pr[i]) fidx = i[3:0];
         if (pr[10 + i]) dig = i[3:0];
      end
      fbit = 10'h001 << fidx;
      any_pr = |pr;
      dtap = any_pr && (kidx == last_q) && (gap_q < dtap_q);
      ctl_mask = gang_q ? gmbr_q : (10'h001 << sel_q);
      m_on = fl_cnt_q < M_ON;
      s_on = fl_cnt_q < S_ON;
      air = ~t2_q;
      chg = air ^ air_prev_q;
      aplay = pend_q & air;
      acue = pend_q & ~air;
      rec_fire = rec_arm_q && (rec_cnt_q >= REC_DLY_CYC - 32'h1);
      auto_go = auto_q && !any_pr && !rec_fire && (|pend_q);
      child_d = child_q;
      if (child_q[3:0] != 4'h9) begin
         child_d[3:0] = child_q[3:0] + 4'h1;
      end else begin
         child_d[3:0] = 4'h0;
         if (child_q[7:4] != 4'h9) begin
            child_d[7:4] = child_q[7:4] + 4'h1;
         end else begin
            child_d[7:4] = 4'h0;
            child_d[11:8] = (child_q[11:8] == 4'h9) ? 4'h0 : child_q[11:8] + 4'h1;
         end
      end
   end
   // ----------------------------------------------------------------
   // Clip store
   // ----------------------------------------------------------------
   always @(posedge clk) begin
      if (clip_in_valid && r2_q[0] && ccnt_q < `RPC_CLIP_MAX) begin
         clip_mem[ccnt_q[8:0]] <= clip_in_desc;
      end
   end
   // ----------------------------------------------------------------
   // Control
   // ----------------------------------------------------------------
   always @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         t1_q <= 10'h3FF;
         t2_q <= 10'h3FF;
         r1_q <= 10'h0;
         r2_q <= 10'h0;
         air_prev_q <= 10'h0;
         pend_q <= 10'h0;
         gmbr_q <= 10'h0;
         rec_q <= 10'h0;
         rec_en_q <= 10'h0;
         sel_q <= 4'h0;
         gkey_q <= 4'h0;
         gang_q <= 1'b0;
         conf_q <= 1'b0;
         auto_q <= 1'b0;
         wclk_q <= 1'b1;
         rec_arm_q <= 1'b0;
         last_q <= 5'h1F;
         gap_q <= 32'h0;
         dtap_q <= `RPC_DTAP_RST;
         rec_cnt_q <= 32'h0;
         sec_cnt_q <= 32'h0;
         fl_cnt_q <= 32'h0;
         tod_q <= 17'h0;
         stc_q <= 17'h0;
         rdur_q <= `RPC_RST_RDUR;
         name_q <= `RPC_RST_NAME;
         name2_q <= `RPC_RST_NAME2;
         sfx_q <= `RPC_RST_SFX;
         child_q <= 12'h0;
         ent_q <= E_IDLE;
         num_q <= 10'h0;
         ccnt_q <= 10'h0;
         cidx_q <= 10'h0;
         csel_q <= 9'h0;
         cvld_q <= 500'h0;
         for (i = 0; i < 10; i = i + 1) loaded_q[i] <= 9'h0;
         deb_prev_q <= {NK{1'b0}};
         reg_rdata_q <= 32'h0;
         green_led_q <= 10'h0;
         red_led_q <= 10'h0;
         disp_chan_q <= 4'h0;
         disp_clip_q <= 9'h0;
         confirm_prompt_q <= 1'b0;
         cmd_valid_q <= 1'b0;
         cmd_code_q <= 3'h0;
         cmd_mask_q <= 10'h0;
         cmd_clip_q <= 9'h0;
         cmd_tc_q <= 17'h0;
         cmd_name_q <= 56'h0;
         cmd_dur_q <= 16'h0;
      end else begin
         t1_q <= tally_input_n;
         t2_q <= t1_q;
         r1_q <= chan_resp;
         r2_q <= r1_q;
         deb_prev_q <= deb;
         air_prev_q <= air;
         cmd_valid_q <= 1'b0;
         fl_cnt_q <= (fl_cnt_q >= FLASH_CYC - 32'h1) ? 32'h0 : fl_cnt_q + 32'h1;
         if (any_pr) begin
            last_q <= kidx;
            gap_q <= 32'h0;
         end else if (gap_q != 32'hFFFFFFFF) begin
            gap_q <= gap_q + 32'h1;
         end
         // Time of day, volatile, seconds of the day
         if (sec_cnt_q >= SEC_CYC - 32'h1) begin
            sec_cnt_q <= 32'h0;
            tod_q <= (tod_q >= `RPC_DAY_S) ? 17'h0 : tod_q + 17'h1;
         end else begin
            sec_cnt_q <= sec_cnt_q + 32'h1;
         end
         if (clip_in_valid && r2_q[0] && ccnt_q < `RPC_CLIP_MAX) begin
            cvld_q[ccnt_q[8:0]] <= 1'b1;
            ccnt_q <= ccnt_q + 10'h1;
         end
         if (rec_arm_q) rec_cnt_q <= rec_cnt_q + 32'h1;
         // Register writes
         if (reg_wr) begin
            if (reg_addr == `RPC_A_CTRL) begin
               auto_q <= reg_wdata[`RPC_B_AUTO];
               wclk_q <= reg_wdata[`RPC_B_WCLK];
               if (reg_wdata[`RPC_B_RELOAD]) begin
                  ccnt_q <= 10'h0;
                  cvld_q <= 500'h0;
               end
            end else if (reg_addr == `RPC_A_DTAP) begin
               dtap_q <= reg_wdata;
            end else if (reg_addr == `RPC_A_RDUR) begin
               rdur_q <= reg_wdata[15:0];
            end else if (reg_addr == `RPC_A_TOD) begin
               tod_q <= reg_wdata[16:0];
               sec_cnt_q <= 32'h0;
            end else if (reg_addr == `RPC_A_STC) begin
               stc_q <= reg_wdata[16:0];
            end else if (reg_addr == `RPC_A_NAME) begin
               name_q <= reg_wdata;
            end else if (reg_addr == `RPC_A_NAME2) begin
               name2_q <= reg_wdata[23:0];
            end else if (reg_addr == `RPC_A_CIDX) begin
               cidx_q <= reg_wdata[9:0];
            end else if (reg_addr == `RPC_A_CDEL) begin
               if (reg_wdata[9:0] < `RPC_CLIP_MAX) cvld_q[reg_wdata[8:0]] <= 1'b0;
            end else if (reg_addr == `RPC_A_SFX0) begin
               sfx_q[31:0] <= reg_wdata;
            end else if (reg_addr == `RPC_A_SFX1) begin
               sfx_q[63:32] <= reg_wdata;
            end else if (reg_addr == `RPC_A_SFX2) begin
               sfx_q[79:64] <= reg_wdata[15:0];
            end
         end
         // Register reads, data in the following cycle
         if (reg_rd) begin
            if (reg_addr == `RPC_A_CTRL) begin
               reg_rdata_q <= {30'h0, wclk_q, auto_q};
            end else if (reg_addr == `RPC_A_STAT) begin
               reg_rdata_q <= {2'h0, conf_q, gang_q, sel_q, 2'h0, rec_en_q, 2'h0, rec_q};
            end else if (reg_addr == `RPC_A_DTAP) begin
               reg_rdata_q <= dtap_q;
            end else if (reg_addr == `RPC_A_RDUR) begin
               reg_rdata_q <= {16'h0, rdur_q};
            end else if (reg_addr == `RPC_A_TOD) begin
               reg_rdata_q <= {15'h0, tod_q};
            end else if (reg_addr == `RPC_A_STC) begin
               reg_rdata_q <= {15'h0, stc_q};
            end else if (reg_addr == `RPC_A_NAME) begin
               reg_rdata_q <= name_q;
            end else if (reg_addr == `RPC_A_NAME2) begin
               reg_rdata_q <= {8'h0, name2_q};
            end else if (reg_addr == `RPC_A_CIDX) begin
               reg_rdata_q <= {22'h0, cidx_q};
            end else if (reg_addr == `RPC_A_CDAT) begin
               reg_rdata_q <= (cidx_q < ccnt_q) ?
                  {15'h0, cvld_q[cidx_q[8:0]], clip_mem[cidx_q[8:0]]} : 32'h0;
            end else if (reg_addr == `RPC_A_CCNT) begin
               reg_rdata_q <= {22'h0, ccnt_q};
            end else if (reg_addr == `RPC_A_SFX0) begin
               reg_rdata_q <= sfx_q[31:0];
            end else if (reg_addr == `RPC_A_SFX1) begin
               reg_rdata_q <= sfx_q[63:32];
            end else if (reg_addr == `RPC_A_SFX2) begin
               reg_rdata_q <= {16'h0, sfx_q[79:64]};
            end else begin
               reg_rdata_q <= 32'h0;
            end
         end
         // Tally changes queue play or cue while auto is on
         if (auto_go) begin
            cmd_valid_q <= 1'b1;
            cmd_code_q <= (|aplay) ? `RPC_CMD_PLAY : `RPC_CMD_CUE;
            cmd_mask_q <= (|aplay) ? aplay : acue;
            pend_q <= (pend_q & ~((|aplay) ? aplay : acue)) | (auto_q ? chg : 10'h0);
         end else begin
            pend_q <= auto_q ? (pend_q | chg) : 10'h0;
         end
         // Key handling
         if (conf_q && any_pr) begin
            conf_q <= 1'b0;
            if (pr[21]) begin
               cmd_valid_q <= 1'b1;
               cmd_code_q <= `RPC_CMD_RSTOP;
               cmd_mask_q <= rec_q;
               rec_q <= 10'h0;
            end
         end else if (deb[22] && any_pr) begin
            if (|pr[9:0]) begin
               rec_en_q <= rec_en_q ^ fbit;
            end else if (pr[23]) begin
               rec_arm_q <= 1'b1;
               rec_cnt_q <= 32'h0;
            end else if (pr[24]) begin
               conf_q <= 1'b1;
            end
         end else if (|pr[9:0]) begin
            if (gang_q && deb[20]) begin
               if (fidx != sel_q) gmbr_q <= gmbr_q ^ fbit;
            end else if (gang_q && dtap && fidx == gkey_q) begin
               gang_q <= 1'b0;
               sel_q <= fidx;
            end else if (gang_q && (gmbr_q & fbit) != 10'h0) begin
               sel_q <= fidx;
            end else if (gang_q) begin
               gang_q <= 1'b0;
               sel_q <= fidx;
            end else if (dtap) begin
               gang_q <= 1'b1;
               gkey_q <= fidx;
               gmbr_q <= fbit;
               sel_q <= fidx;
            end else begin
               sel_q <= fidx;
            end
         end else if (any_pr) begin
            case (ent_q)
               E_IDLE: begin
                  if (pr[20]) begin
                     ent_q <= E_HOME;
                     num_q <= 10'h0;
                  end
               end
               E_HOME, E_NUM: begin
                  if (pr[20]) begin
                     ent_q <= E_HOME;
                     num_q <= 10'h0;
                  end else if (|pr[19:10]) begin
                     ent_q <= E_NUM;
                     num_q <= (num_q > 10'h063) ? 10'h3E7 : num_q * 10'hA + {6'h0, dig};
                  end else if (pr[21]) begin
                     ent_q <= E_IDLE;
                     if (ent_q == E_HOME) begin
                        csel_q <= loaded_q[sel_q];
                     end else if (num_q < ccnt_q) begin
                        csel_q <= num_q[8:0];
                     end
                  end else begin
                     ent_q <= E_IDLE;
                  end
               end
               default: ent_q <= E_IDLE;
            endcase
            if (pr[25]) begin
               cmd_valid_q <= 1'b1;
               cmd_code_q <= `RPC_CMD_LOAD;
               cmd_mask_q <= ctl_mask;
               cmd_clip_q <= csel_q;
               for (i = 0; i < 10; i = i + 1) begin
                  if (ctl_mask[i]) loaded_q[i] <= csel_q;
               end
            end else if (pr[23]) begin
               cmd_valid_q <= 1'b1;
               cmd_code_q <= `RPC_CMD_PLAY;
               cmd_mask_q <= auto_q ? (ctl_mask & air) : ctl_mask;
            end else if (pr[24]) begin
               cmd_valid_q <= 1'b1;
               cmd_code_q <= `RPC_CMD_CUE;
               cmd_mask_q <= ctl_mask;
            end else if (pr[26]) begin
               child_q <= child_d;
               cmd_valid_q <= 1'b1;
               cmd_code_q <= `RPC_CMD_CHILD;
               cmd_mask_q <= ctl_mask;
               cmd_name_q <= {name_q, 4'h3, child_d[11:8], 4'h3, child_d[7:4],
                              4'h3, child_d[3:0]};
            end
         end
         // Delayed record start wins over all other commands
         if (rec_fire) begin
            rec_arm_q <= 1'b0;
            rec_q <= rec_q | rec_en_q;
            name_q[7:0] <= name_q[7:0] + 8'h01;
            cmd_valid_q <= 1'b1;
            cmd_code_q <= `RPC_CMD_RSTART;
            cmd_mask_q <= rec_en_q;
            cmd_tc_q <= wclk_q ? tod_q : stc_q;
            cmd_name_q <= {name_q[31:8], name_q[7:0] + 8'h01, name2_q};
            cmd_dur_q <= rdur_q;
         end
         // Indicators and status display
         for (i = 0; i < 10; i = i + 1) begin
            if (!gang_q) begin
               green_led_q[i] <= (sel_q == i[3:0]);
            end else if (sel_q == i[3:0]) begin
               green_led_q[i] <= m_on;
            end else begin
               green_led_q[i] <= gmbr_q[i] & s_on;
            end
            red_led_q[i] <= rec_q[i] |
               (deb[22] & rec_en_q[i] & (r2_q[i] | s_on));
         end
         disp_chan_q <= sel_q;
         disp_clip_q <= loaded_q[sel_q];
         confirm_prompt_q <= conf_q;
      end
   end
endmodule // rpc_panel
`default_nettype wire

// file: rpc_srv_model.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------
// Server channels: link state, tallies, clip feed
// ------------------------------------------
module rpc_srv_model #(parameter int NCLIP = 5) (
   input wire logic clk,
   input wire logic [9:0] up,
   input wire logic [9:0] air,
   output logic [9:0] chan_resp,
   output logic [9:0] tally_input_n,
   output logic clip_in_valid,
   output logic [15:0] clip_in_desc
);
   int sent = 0;
   logic [3:0] up_d = '0;
   assign chan_resp = up;
   assign tally_input_n = ~air;
   // Feed starts a few cycles after the link is up, once the panel sees it
   always @(posedge clk) begin
      up_d <= {up_d[2:0], up[0]};
      clip_in_valid <= up_d[3] && sent < NCLIP && !clip_in_valid;
      clip_in_desc <= 16'hC100 + 16'(sent);
      if (up_d[3] && sent < NCLIP && !clip_in_valid) begin
         sent <= sent + 1;
      end
   end
endmodule // rpc_srv_model
`default_nettype wire

// file: rpc_panel_asserts.sv
`timescale 1ns/1ps
`default_nettype none
`include "rpc_consts.vh"
module rpc_panel_chk (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [7:0] reg_addr,
   input wire logic reg_rd,
   input wire logic [31:0] reg_rdata_q,
   input wire logic [9:0] red_led_q,
   input wire logic confirm_prompt_q,
   input wire logic cmd_valid_q,
   input wire logic [2:0] cmd_code_q,
   input wire logic [9:0] cmd_mask_q
);
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   sequence s_start;
      cmd_valid_q && cmd_code_q == `RPC_CMD_RSTART;
   endsequence
   sequence s_stop;
      cmd_valid_q && cmd_code_q == `RPC_CMD_RSTOP;
   endsequence
   chk_cmd_pulse: assert property (cmd_valid_q |=> !cmd_valid_q)
      else $error("command valid held over one cycle");
   chk_cmd_code: assert property (cmd_valid_q |-> cmd_code_q inside {[3'h1:3'h6]})
      else $error("command code out of range");
   chk_start_red: assert property (s_start |-> ##[0:2] (red_led_q & cmd_mask_q) == cmd_mask_q)
      else $error("recording channel red led dark");
   chk_stop_prompt: assert property (s_stop |-> $past(confirm_prompt_q))
      else $error("stop all issued without prompt");
   chk_prompt_quiet: assert property ($rose(confirm_prompt_q) |-> !cmd_valid_q)
      else $error("prompt raised together with a command");
   chk_reset_quiet: assert property ($fell(sys_rst) |-> (red_led_q == 10'h000 && !cmd_valid_q) [*2])
      else $error("outputs active right after reset");
   chk_rdata_hold: assert property (!$past(reg_rd) |-> $stable(reg_rdata_q))
      else $error("read data changed without read");
   chk_unmapped_zero: assert property (reg_rd && reg_addr > 8'h3B |=> reg_rdata_q == 32'h0)
      else $error("unmapped read not zero");
endmodule // rpc_panel_chk
bind rpc_panel rpc_panel_chk u_chk (.clk, .sys_rst, .reg_addr, .reg_rd, .reg_rdata_q, .red_led_q,
   .confirm_prompt_q, .cmd_valid_q, .cmd_code_q, .cmd_mask_q);
`default_nettype wire

// file: tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "rpc_consts.vh"
module tb_top;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic [26:0] kb = '0;
   logic [9:0] up = '0, air = '0;
   logic [7:0] reg_addr = '0;
   logic [31:0] reg_wdata = '0, reg_rdata_q;
   logic reg_wr = 1'b0, reg_rd = 1'b0;
   logic [9:0] chan_resp, tally_input_n, green_led_q, red_led_q, cmd_mask_q;
   logic [3:0] disp_chan_q;
   logic [8:0] disp_clip_q, cmd_clip_q;
   logic confirm_prompt_q, cmd_valid_q, clip_in_valid;
   logic [2:0] cmd_code_q;
   logic [16:0] cmd_tc_q;
   logic [55:0] cmd_name_q;
   logic [15:0] cmd_dur_q, clip_in_desc;
   int cyc = 0, fail_count = 0, checks = 0;
   always #10 clk = ~clk;
   rpc_panel #(.DEB_CYC(32'h2), .REC_DLY_CYC(32'h14), .SEC_CYC(32'hA), .FLASH_CYC(32'h8)) u_dut (
      .clk, .sys_rst, .channel_function_keys(kb[9:0]), .digit_keys(kb[19:10]),
      .home_key(kb[20]), .enter_key(kb[21]), .capture_key(kb[22]), .play_key(kb[23]),
      .stop_key(kb[24]), .load_key(kb[25]), .child_key(kb[26]), .tally_input_n, .chan_resp,
      .clip_in_valid, .clip_in_desc, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata_q,
      .green_led_q, .red_led_q, .disp_chan_q, .disp_clip_q, .confirm_prompt_q, .cmd_valid_q,
      .cmd_code_q, .cmd_mask_q, .cmd_clip_q, .cmd_tc_q, .cmd_name_q, .cmd_dur_q);
   rpc_srv_model u_srv (.clk, .up, .air, .chan_resp, .tally_input_n, .clip_in_valid, .clip_in_desc);
   // ------------------------------------------
   // Shared tasks
   // ------------------------------------------
   task automatic end_sim;
      $display("checks=%0d fail_count=%0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 4000) begin
         fail_count++;
         end_sim;
      end
   end
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         fail_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic flash(input int b, input int n, input bit r);
      int k;
      k = 0;
      repeat (8) begin
         @(negedge clk) k += r ? red_led_q[b] : green_led_q[b];
      end
      cmp(k, n);
   endtask
   task automatic hold(input int k, input logic v);
      @(posedge clk) kb[k] <= v;
      repeat (8) @(posedge clk);
      @(negedge clk);
   endtask
   task automatic tap(input int k);
      hold(k, 1'b1);
      hold(k, 1'b0);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk) {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
      @(posedge clk) reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      @(posedge clk) {reg_addr, reg_rd} <= {a, 1'b1};
      @(posedge clk) reg_rd <= 1'b0;
      @(negedge clk) cmp(reg_rdata_q, e);
   endtask
   task automatic wait_cmd(input logic [2:0] c);
      for (int i = 0; i < 80; i++) begin
         @(negedge clk);
         if (cmd_valid_q === 1'b1 && cmd_code_q === c) break;
      end
      cmp({cmd_valid_q, cmd_code_q}, {1'b1, c});
   endtask
   // ------------------------------------------
   // Scenarios
   // ------------------------------------------
   initial begin
      int t0;
      repeat (16) @(posedge clk);
      sys_rst <= 1'b0;
      up <= 10'h3FF;
      rd(`RPC_A_SFX0, 32'h49484746);
      rd(`RPC_A_SFX2, 32'h00004544);
      wr(`RPC_A_SFX2, 32'h00004B4C);
      rd(`RPC_A_SFX2, 32'h00004B4C);
      rd(`RPC_A_RDUR, 32'h00000708);
      rd(`RPC_A_NAME, 32'h52454330);
      rd(`RPC_A_CTRL, 32'h00000002);
      rd(8'h40, 32'h0);
      $display("test registers done");
      tap(3);
      cmp(green_led_q, 10'h008);
      tap(5);
      cmp(green_led_q, 10'h020);
      $display("test select done");
      rd(`RPC_A_CCNT, 32'h5);
      tap(20);
      tap(11);
      tap(21);
      fork
         tap(25);
         begin
            wait_cmd(3'h1);
            cmp(cmd_clip_q, 9'h001);
            cmp(cmd_mask_q, 10'h020);
         end
      join
      cmp(disp_clip_q, 9'h001);
      wr(`RPC_A_CTRL, 32'h6);
      rd(`RPC_A_CCNT, 32'h0);
      $display("test clips done");
      wr(`RPC_A_TOD, 32'h64);
      hold(22, 1'b1);
      tap(1);
      tap(2);
      rd(`RPC_A_STAT, 32'h05006000);
      cmp(red_led_q, 10'h006);
      t0 = cyc;
      fork
         tap(23);
         begin
            wait_cmd(3'h4);
            cmp(cmd_mask_q, 10'h006);
            cmp(cyc - t0 inside {[22:34]}, 1'b1);
            cmp(cmd_name_q[55:24], 32'h52454331);
            cmp(cmd_dur_q, 16'h0708);
            cmp(cmd_tc_q inside {[100:110]}, 1'b1);
         end
      join
      hold(22, 1'b0);
      cmp(red_led_q, 10'h006);
      hold(22, 1'b1);
      tap(24);
      cmp(confirm_prompt_q, 1'b1);
      hold(22, 1'b0);
      tap(23);
      cmp(confirm_prompt_q, 1'b0);
      cmp(red_led_q, 10'h006);
      hold(22, 1'b1);
      tap(24);
      hold(22, 1'b0);
      fork
         tap(21);
         begin
            wait_cmd(3'h5);
            cmp(cmd_mask_q, 10'h006);
         end
      join
      cmp(red_led_q, 10'h000);
      hold(22, 1'b1);
      @(posedge clk) up <= 10'h3FD;
      repeat (4) @(posedge clk);
      flash(1, 2, 1'b1);
      @(posedge clk) up <= 10'h3FF;
      hold(22, 1'b0);
      $display("test record done");
      wr(`RPC_A_CTRL, 32'h3);
      fork
         @(posedge clk) air <= 10'h004;
         wait_cmd(3'h2);
      join
      cmp(cmd_mask_q[2], 1'b1);
      fork
         @(posedge clk) air <= 10'h000;
         wait_cmd(3'h3);
      join
      cmp(cmd_mask_q[2], 1'b1);
      $display("test auto done");
      fork
         tap(26);
         begin
            wait_cmd(3'h6);
            cmp(cmd_name_q[23:0], 24'h303031);
            cmp(cmd_name_q[55:24], 32'h52454331);
         end
      join
      $display("test child done");
      tap(7);
      tap(7);
      flash(7, 6, 1'b0);
      hold(20, 1'b1);
      tap(8);
      hold(20, 1'b0);
      rd(`RPC_A_STAT, 32'h17006000);
      flash(8, 2, 1'b0);
      cmp(disp_chan_q, 4'h7);
      tap(8);
      cmp(disp_chan_q, 4'h8);
      flash(8, 6, 1'b0);
      flash(7, 2, 1'b0);
      tap(2);
      cmp(green_led_q, 10'h004);
      tap(7);
      tap(7);
      tap(7);
      cmp(green_led_q, 10'h080);
      $display("test gang done");
      end_sim;
   end
endmodule // tb_top
`default_nettype wire
